// [include/brfpc_pkg.sv]
// brfpc_pkg: constants and types of the banked register file and program counter
// assumes one 100 MHz core clock and a synchronous active-high reset
package brfpc_pkg;
   // clock and timing
   localparam int CLK_NS        = 10;
   localparam int TRAP_HOLD_NS  = 1000;
   localparam int TRAP_CYC      = (TRAP_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRAP_CW       = 8;
   // program counter
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
   localparam logic [15:0] PREFETCH    = 16'h0002;
   localparam logic [15:0] PC_RST      = 16'h0000;
   // data memory map
   localparam logic [15:0] RAM_LO      = 16'h0040;
   localparam logic [15:0] RAM_HI      = 16'h043F;
   localparam logic [15:0] BANK_HI     = 16'h00BF;
   localparam logic [15:0] DIR_HI      = 16'h00FF;
   localparam logic [15:0] PSW_ADDR    = 16'h003F;
   // register slots inside a bank (pair low byte at even slot)
   localparam logic [2:0] IX_A = 3'h0;
   localparam logic [2:0] IX_W = 3'h1;
   localparam logic [2:0] IX_C = 3'h2;
   localparam logic [2:0] IX_L = 3'h6;
   localparam logic [2:0] IX_H = 3'h7;
   localparam logic [2:0] IX_E = 3'h4;
   localparam logic [2:0] IX_D = 3'h5;
   // status word fields
   localparam int PSW_JF = 7;
   localparam int PSW_ZF = 6;
   localparam int PSW_CF = 5;
   localparam int PSW_HF = 4;
   localparam logic [3:0] BANK_RST = 4'h0;

   typedef enum logic [1:0] {BT_HI, BT_LO, BT_LD, BT_RUN} brfpc_boot_t;
   typedef enum logic [2:0] {PM_HL, PM_HL_D, PM_HL_C, PM_HL_INC, PM_DEC_HL, PM_DE} brfpc_ptr_t;
   typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} brfpc_alu_t;

   typedef struct packed {
      brfpc_boot_t         boot;
      logic [15:0]         rom_addr;
      logic [7:0]          vec_hi;
      logic [15:0]         pc;
      logic [15:0]         insn;
      logic [3:0]          bank;
      logic                jf;
      logic                zf;
      logic                cf;
      logic                hf;
      logic [7:0]          mem_rd;
      logic                mem_hit;
      logic [7:0]          reg_rd;
      logic [15:0]         pair_rd;
      logic                trap;
      logic [TRAP_CW-1:0]  trap_cnt;
   } brfpc_st_t;
endpackage : brfpc_pkg

// [rtl/brfpc_core.sv]
// brfpc_core: program counter, data memory, banked registers and status word
// assumes the execution unit issues at most one register-side operation per cycle
// and program memory answers rom_addr_out one cycle later on rom_data_in
`timescale 1ns/1ps
`default_nettype none
module brfpc_core
   import brfpc_pkg::*;
#(
   parameter int RAM_BYTES = 1024
) (
   // clock and reset
   input  wire  logic        core_clk_in,
   input  wire  logic        rst_in,
   // program memory for the vector
   output var   logic [15:0] rom_addr_out,
   input  wire  logic [7:0]  rom_data_in,
   // program counter control
   input  wire  logic        pc_step_in,
   input  wire  logic [2:0]  pc_len_in,
   input  wire  logic        pc_jump_in,
   input  wire  logic [15:0] pc_target_in,
   output var   logic [15:0] pc_out,
   output var   logic [15:0] fetch_addr_out,
   // reset pin, open drain
   output var   logic        reset_pin_out,
   output var   logic        reset_pin_oe_n_out,
   // data memory access
   input  wire  logic        mem_req_in,
   input  wire  logic        mem_wr_in,
   input  wire  logic        mem_short_in,
   input  wire  logic [7:0]  mem_dir_in,
   input  wire  logic [15:0] mem_addr_in,
   input  wire  logic [7:0]  mem_wdata_in,
   output var   logic [7:0]  mem_rdata_out,
   output var   logic        mem_hit_out,
   // pointer access
   input  wire  logic        ptr_req_in,
   input  wire  logic        ptr_wr_in,
   input  wire  brfpc_ptr_t  ptr_mode_in,
   input  wire  logic [7:0]  ptr_disp_in,
   input  wire  logic [7:0]  ptr_wdata_in,
   // register access
   input  wire  logic [2:0]  reg_idx_in,
   input  wire  logic        reg_wr_in,
   input  wire  logic [7:0]  reg_wdata_in,
   output var   logic [7:0]  reg_rdata_out,
   input  wire  logic [1:0]  pair_idx_in,
   input  wire  logic        pair_wr_in,
   input  wire  logic [15:0] pair_wdata_in,
   output var   logic [15:0] pair_rdata_out,
   // arithmetic
   input  wire  logic        alu_req_in,
   input  wire  brfpc_alu_t  alu_op_in,
   input  wire  logic [2:0]  alu_dst_in,
   input  wire  logic [7:0]  alu_src_in,
   input  wire  logic        div_req_in,
   // status word
   input  wire  logic        bank_load_in,
   input  wire  logic [3:0]  bank_in,
   input  wire  logic        psw_load_in,
   input  wire  logic [7:0]  psw_val_in,
   input  wire  logic        flags_we_in,
   input  wire  logic [3:0]  flags_in,
   output var   logic [7:0]  psw_out
);
   generate
      if (RAM_BYTES != 1024) begin : g_bad_size
         $error("brfpc_core: RAM_BYTES must match the 0040-043F map");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0]  ram [RAM_BYTES];
   brfpc_st_t   st_q;
   brfpc_st_t   st_d;
   logic        we [3];
   logic [9:0]  wa [3];
   logic [7:0]  wd [3];

   function automatic logic in_ram(input logic [15:0] a);
      return (a >= RAM_LO) && (a <= RAM_HI);
   endfunction : in_ram

   function automatic logic [9:0] ram_ix(input logic [15:0] a);
      logic [15:0] off;
      off = a - RAM_LO;
      return off[9:0];
   endfunction : ram_ix

   function automatic logic [9:0] reg_ix(input logic [3:0] b, input logic [2:0] r);
      return {3'b000, b, r};
   endfunction : reg_ix

   ////////////////////////////////////////////////////////////////////////
   // next state
   logic [15:0] hl, de, ea, acc_addr;
   logic        acc_wr;
   logic [7:0]  acc_wdat;
   logic [7:0]  dst;
   logic [8:0]  sum;
   logic [4:0]  nib;
   logic [15:0] wa_pair, quo, rem;
   logic [7:0]  dv;
   logic [7:0]  program_status_word;

   always_comb begin
      st_d = st_q;
      we = '{default: 1'b0};
      wa = '{default: 10'h000};
      wd = '{default: 8'h00};
      program_status_word = {st_q.jf, st_q.zf, st_q.cf, st_q.hf, st_q.bank};
      hl = {ram[reg_ix(st_q.bank, IX_H)], ram[reg_ix(st_q.bank, IX_L)]};
      de = {ram[reg_ix(st_q.bank, IX_D)], ram[reg_ix(st_q.bank, IX_E)]};
      // pointer address
      unique case (ptr_mode_in)
         PM_HL_D:   ea = hl + {{8{ptr_disp_in[7]}}, ptr_disp_in};
         PM_HL_C:   ea = hl + {8'h00, ram[reg_ix(st_q.bank, IX_C)]};
         PM_DEC_HL: ea = hl - 16'h0001;
         PM_DE:     ea = de;
         default:   ea = hl;
      endcase
      acc_addr = ptr_req_in ? ea : (mem_short_in ? {8'h00, mem_dir_in} : mem_addr_in);
      acc_wr   = ptr_req_in ? ptr_wr_in : mem_wr_in;
      acc_wdat = ptr_req_in ? ptr_wdata_in : mem_wdata_in;
      // data access
      st_d.mem_hit = 1'b0;
      if (ptr_req_in || mem_req_in) begin
         st_d.mem_hit = in_ram(acc_addr) || (acc_addr == PSW_ADDR);
         st_d.mem_rd  = 8'h00;
         if (acc_addr == PSW_ADDR) begin
            st_d.mem_rd = program_status_word;
            if (acc_wr) begin
               st_d.bank = acc_wdat[3:0];
               st_d.jf   = 1'b1;
            end
         end else if (in_ram(acc_addr)) begin
            st_d.mem_rd = ram[ram_ix(acc_addr)];
            we[0] = acc_wr;
            wa[0] = ram_ix(acc_addr);
            wd[0] = acc_wdat;
         end
      end
      // register side, one operation per cycle
      wa_pair = {ram[reg_ix(st_q.bank, IX_W)], ram[reg_ix(st_q.bank, IX_A)]};
      dv      = ram[reg_ix(st_q.bank, IX_C)];
      quo     = (dv != 8'h00) ? wa_pair / {8'h00, dv} : 16'h0000;
      rem     = (dv != 8'h00) ? wa_pair % {8'h00, dv} : 16'h0000;
      dst     = ram[reg_ix(st_q.bank, alu_dst_in)];
      sum     = 9'h000;
      nib     = 5'h00;
      if (div_req_in) begin
         st_d.cf = (dv == 8'h00) || (quo[15:8] != 8'h00);
         st_d.zf = (rem[7:0] == 8'h00);
         st_d.jf = st_d.cf;
         if (!st_d.cf) begin
            we[1] = 1'b1;
            wa[1] = reg_ix(st_q.bank, IX_A);
            wd[1] = quo[7:0];
            we[2] = 1'b1;
            wa[2] = reg_ix(st_q.bank, IX_W);
            wd[2] = rem[7:0];
         end
      end else if (alu_req_in) begin
         unique case (alu_op_in)
            ALU_ADD: begin
               sum = {1'b0, dst} + {1'b0, alu_src_in};
               nib = {1'b0, dst[3:0]} + {1'b0, alu_src_in[3:0]};
            end
            ALU_SUB: begin
               sum = {1'b0, dst} - {1'b0, alu_src_in};
               nib = {1'b0, dst[3:0]} - {1'b0, alu_src_in[3:0]};
            end
            ALU_AND: sum = {1'b0, dst & alu_src_in};
            ALU_OR:  sum = {1'b0, dst | alu_src_in};
            default: sum = {1'b0, dst ^ alu_src_in};
         endcase
         st_d.zf = (sum[7:0] == 8'h00);
         if (alu_op_in == ALU_ADD || alu_op_in == ALU_SUB) begin
            st_d.cf = sum[8];
            st_d.hf = nib[4];
            st_d.jf = sum[8];
         end else begin
            st_d.jf = st_d.zf;
         end
         we[1] = 1'b1;
         wa[1] = reg_ix(st_q.bank, alu_dst_in);
         wd[1] = sum[7:0];
      end else if (pair_wr_in) begin
         we[1] = 1'b1;
         wa[1] = reg_ix(st_q.bank, {pair_idx_in, 1'b0});
         wd[1] = pair_wdata_in[7:0];
         we[2] = 1'b1;
         wa[2] = reg_ix(st_q.bank, {pair_idx_in, 1'b1});
         wd[2] = pair_wdata_in[15:8];
      end else if (reg_wr_in) begin
         we[1] = 1'b1;
         wa[1] = reg_ix(st_q.bank, reg_idx_in);
         wd[1] = reg_wdata_in;
      end else if (ptr_req_in && (ptr_mode_in == PM_HL_INC || ptr_mode_in == PM_DEC_HL)) begin
         we[1] = 1'b1;
         wa[1] = reg_ix(st_q.bank, IX_L);
         wd[1] = (ptr_mode_in == PM_HL_INC) ? hl[7:0] + 8'h01 : ea[7:0];
         we[2] = 1'b1;
         wa[2] = reg_ix(st_q.bank, IX_H);
         wd[2] = (ptr_mode_in == PM_HL_INC) ? 8'((hl + 16'h0001) >> 8) : ea[15:8];
      end
      // status word instructions
      if (psw_load_in) begin
         {st_d.jf, st_d.zf, st_d.cf, st_d.hf, st_d.bank} = psw_val_in;
      end else if (bank_load_in) begin
         st_d.bank = bank_in;
         st_d.jf   = 1'b1;
      end
      if (flags_we_in) begin
         {st_d.jf, st_d.zf, st_d.cf, st_d.hf} = flags_in;
      end
      // register reads
      st_d.reg_rd  = ram[reg_ix(st_q.bank, reg_idx_in)];
      st_d.pair_rd = {ram[reg_ix(st_q.bank, {pair_idx_in, 1'b1})],
                      ram[reg_ix(st_q.bank, {pair_idx_in, 1'b0})]};
      // vector load and program counter
      unique case (st_q.boot)
         BT_HI: begin
            st_d.boot     = BT_LO;
            st_d.rom_addr = VEC_LO_ADDR;
         end
         BT_LO: begin
            st_d.boot   = BT_LD;
            st_d.vec_hi = rom_data_in;
         end
         BT_LD: begin
            st_d.boot = BT_RUN;
            st_d.insn = {st_q.vec_hi, rom_data_in};
            st_d.pc   = {st_q.vec_hi, rom_data_in} + PREFETCH;
         end
         BT_RUN: begin
            if (pc_jump_in) begin
               st_d.insn = pc_target_in;
               st_d.pc   = pc_target_in + PREFETCH;
            end else if (pc_step_in) begin
               st_d.insn = st_q.insn + {13'h0000, pc_len_in};
               st_d.pc   = st_q.insn + {13'h0000, pc_len_in} + PREFETCH;
            end
            if (st_q.trap) begin
               st_d.trap_cnt = st_q.trap_cnt - 1'b1;
               st_d.trap     = (st_q.trap_cnt != '0);
            end else if (in_ram(st_q.insn)) begin
               st_d.trap     = 1'b1;
               st_d.trap_cnt = TRAP_CW'(TRAP_CYC - 1);
            end
         end
      endcase
      if (rst_in) begin
         st_d.boot     = BT_HI;
         st_d.rom_addr = VEC_HI_ADDR;
         st_d.vec_hi   = 8'h00;
         st_d.pc       = PC_RST;
         st_d.insn     = PC_RST;
         st_d.bank     = BANK_RST;
         st_d.jf       = 1'b1;
         st_d.mem_rd   = 8'h00;
         st_d.mem_hit  = 1'b0;
         st_d.reg_rd   = 8'h00;
         st_d.pair_rd  = 16'h0000;
         st_d.trap     = 1'b0;
         st_d.trap_cnt = '0;
         we = '{default: 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge core_clk_in) begin
      st_q <= st_d;
   end

   always_ff @(posedge core_clk_in) begin
      for (int i = 0; i < 3; i++) begin
         if (we[i]) begin
            ram[wa[i]] <= wd[i];
         end
      end
   end

   assign rom_addr_out       = st_q.rom_addr;
   assign pc_out             = st_q.pc;
   assign fetch_addr_out     = st_q.insn;
   assign reset_pin_out      = 1'b0;
   assign reset_pin_oe_n_out = ~st_q.trap;
   assign mem_rdata_out      = st_q.mem_rd;
   assign mem_hit_out        = st_q.mem_hit;
   assign reg_rdata_out      = st_q.reg_rd;
   assign pair_rdata_out     = st_q.pair_rd;
   assign psw_out            = {st_q.jf, st_q.zf, st_q.cf, st_q.hf, st_q.bank};

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_boot;
      st_q.boot == BT_HI ##1 st_q.boot == BT_LO ##1 st_q.boot == BT_LD;
   endsequence

   chk_boot_vector: assert property (
      s_boot |=> (st_q.insn == {$past(st_q.vec_hi), $past(rom_data_in)}) && st_q.boot == BT_RUN)
      else $error("reset vector not loaded");
   chk_boot_addr: assert property (
      $fell(rst_in) |-> rom_addr_out == VEC_HI_ADDR ##1 rom_addr_out == VEC_LO_ADDR)
      else $error("vector addresses wrong");
   chk_pc_prefetch: assert property (
      st_q.boot == BT_RUN |-> pc_out == fetch_addr_out + PREFETCH)
      else $error("counter not two ahead");
   chk_pc_step: assert property (
      st_q.boot == BT_RUN && pc_step_in && !pc_jump_in
      |=> fetch_addr_out == $past(fetch_addr_out) + {13'h0000, $past(pc_len_in)})
      else $error("counter step wrong");
   chk_trap_pin: assert property (
      st_q.boot == BT_RUN && !st_q.trap && in_ram(st_q.insn) |=> !reset_pin_oe_n_out && !reset_pin_out)
      else $error("trap not driven");
   chk_bank_reset: assert property (
      $fell(rst_in) |-> psw_out[3:0] == BANK_RST && psw_out[PSW_JF])
      else $error("bank or jump flag not reset");
   chk_psw_write: assert property (
      mem_req_in && mem_wr_in && !mem_short_in && !ptr_req_in && mem_addr_in == PSW_ADDR
      && !psw_load_in && !bank_load_in && !flags_we_in && !alu_req_in && !div_req_in
      |=> psw_out == {1'b1, $past(psw_out[6:4]), $past(mem_wdata_in[3:0])})
      else $error("status write touched flags");
   chk_acc_alias: assert property (
      mem_req_in && !mem_wr_in && !ptr_req_in && !mem_short_in && mem_addr_in == RAM_LO
      |=> mem_rdata_out == $past(ram[reg_ix(BANK_RST, IX_A)]) && mem_hit_out)
      else $error("0040 differs from bank 0 accumulator");
   chk_ptr_inc: assert property (
      ptr_req_in && ptr_mode_in == PM_HL_INC && !ptr_wr_in && !div_req_in && !alu_req_in
      && !pair_wr_in && !reg_wr_in && !psw_load_in && !bank_load_in
      |=> hl == $past(hl) + 16'h0001)
      else $error("pointer not incremented");
   chk_div_result: assert property (
      div_req_in && dv != 8'h00 && quo[15:8] == 8'h00 && !psw_load_in && !bank_load_in && !flags_we_in
      |=> wa_pair == {$past(rem[7:0]), $past(quo[7:0])} && !psw_out[PSW_CF])
      else $error("division result wrong");
endmodule : brfpc_core
`default_nettype wire

// [sim/banked_register_file_pc_tb.sv]
// banked_register_file_pc_tb: self-checking bench for brfpc_core
// assumes 100 MHz clock and one-cycle registered answers
`timescale 1ns/1ps
`default_nettype none
module banked_register_file_pc_tb
   import brfpc_pkg::*;
;
   localparam logic [12:0] IDL = 13'h0000, MRD = 13'h0001, MWR = 13'h0003, PRD = 13'h0004;
   localparam logic [12:0] PWR = 13'h000C, RWR = 13'h0010, PRW = 13'h0020, ALU = 13'h0040;
   localparam logic [12:0] DIV = 13'h0080, BNK = 13'h0100, PSL = 13'h0200, FLG = 13'h0400;
   localparam logic [12:0] STP = 13'h0800, JMP = 13'h1000;
   localparam int K_MEM = 0, K_HIT = 1, K_REG = 2, K_PAIR = 3, K_PSW = 4;
   localparam int K_PC = 5, K_FET = 6, K_OEN = 7, K_PIN = 8, K_JB = 9, K_ROM = 10;
   localparam int LIMIT = 2000;
   typedef struct {int due; int kind; logic [15:0] val;} brfpc_note_t;
   ////////////////////////////////////////////////
   logic        core_clk_in   = 1'b0;
   logic        rst_in        = 1'b1;
   logic [12:0] stb           = IDL;
   logic        mem_req_in, mem_wr_in, ptr_req_in, ptr_wr_in, reg_wr_in, pair_wr_in, alu_req_in;
   logic        div_req_in, bank_load_in, psw_load_in, flags_we_in, pc_step_in, pc_jump_in;
   logic        mem_short_in  = 1'b0;
   logic [2:0]  pc_len_in     = 3'h0;
   logic [15:0] pc_target_in  = 16'h0000;
   logic [7:0]  mem_dir_in    = 8'h00;
   logic [15:0] mem_addr_in   = 16'h0000;
   logic [7:0]  mem_wdata_in  = 8'h00;
   brfpc_ptr_t  ptr_mode_in   = PM_HL;
   logic [7:0]  ptr_disp_in   = 8'h00;
   logic [7:0]  ptr_wdata_in  = 8'h00;
   logic [2:0]  reg_idx_in    = 3'h0;
   logic [7:0]  reg_wdata_in  = 8'h00;
   logic [1:0]  pair_idx_in   = 2'h0;
   logic [15:0] pair_wdata_in = 16'h0000;
   brfpc_alu_t  alu_op_in     = ALU_ADD;
   logic [2:0]  alu_dst_in    = 3'h0;
   logic [7:0]  alu_src_in    = 8'h00;
   logic [3:0]  bank_in       = 4'h0;
   logic [7:0]  psw_val_in    = 8'h00;
   logic [3:0]  flags_in      = 4'h0;
   logic [15:0] rom_addr_out, pc_out, fetch_addr_out, pair_rdata_out;
   logic [7:0]  rom_data_in, mem_rdata_out, reg_rdata_out, psw_out;
   logic        reset_pin_out, reset_pin_oe_n_out, mem_hit_out;
   brfpc_note_t notes[$];
   int          cyc           = 0;
   int          mismatches    = 0;
   int          checks_done   = 0;
   logic [15:0] a, w;
   logic [7:0]  x, y, c;
   logic [7:0]  d[6];
   logic [15:0] edges[4]      = '{16'h0040, 16'h043F, 16'h003E, 16'h0440};

   assign {pc_jump_in, pc_step_in, flags_we_in, psw_load_in, bank_load_in, div_req_in, alu_req_in,
           pair_wr_in, reg_wr_in, ptr_wr_in, ptr_req_in, mem_wr_in, mem_req_in} = stb;
   always #(CLK_NS / 2) core_clk_in = ~core_clk_in;

   brfpc_core dut (
      .core_clk_in, .rst_in, .rom_addr_out, .rom_data_in, .pc_step_in, .pc_len_in, .pc_jump_in,
      .pc_target_in, .pc_out, .fetch_addr_out, .reset_pin_out, .reset_pin_oe_n_out, .mem_req_in,
      .mem_wr_in, .mem_short_in, .mem_dir_in, .mem_addr_in, .mem_wdata_in, .mem_rdata_out,
      .mem_hit_out, .ptr_req_in, .ptr_wr_in, .ptr_mode_in, .ptr_disp_in, .ptr_wdata_in, .reg_idx_in,
      .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .pair_idx_in, .pair_wr_in, .pair_wdata_in,
      .pair_rdata_out, .alu_req_in, .alu_op_in, .alu_dst_in, .alu_src_in, .div_req_in, .bank_load_in,
      .bank_in, .psw_load_in, .psw_val_in, .flags_we_in, .flags_in, .psw_out
   );
   brfpc_rom_model rom (.core_clk_in(core_clk_in), .rom_addr_in(rom_addr_out), .rom_data_out(rom_data_in));
   ////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      checks_done++;
      if (got !== want) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, got, want);
      end
   endtask : check
   task automatic note(input int kind, input logic [15:0] val, input int dly = 1);
      notes.push_back('{cyc + dly, kind, val});
   endtask : note
   task automatic op(input logic [12:0] s);
      @(negedge core_clk_in);
      stb = s;
   endtask : op
   task automatic put_addr(input logic [15:0] ad, input logic s);
      mem_short_in = s;
      mem_dir_in = ad[7:0];
      mem_addr_in = s ? ~ad : ad;
   endtask : put_addr
   task automatic wr(input logic [15:0] ad, input logic [7:0] v, input logic s = 1'b0);
      op(MWR);
      put_addr(ad, s);
      mem_wdata_in = v;
   endtask : wr
   task automatic rd(input logic [15:0] ad, input logic [7:0] e, input logic h, input logic s = 1'b0);
      op(MRD);
      put_addr(ad, s);
      note(K_MEM, {8'h00, e});
      note(K_HIT, {15'h0000, h});
   endtask : rd
   task automatic wreg(input logic [2:0] i, input logic [7:0] v);
      op(RWR);
      reg_idx_in = i;
      reg_wdata_in = v;
   endtask : wreg
   task automatic wpair(input logic [1:0] k, input logic [15:0] v);
      op(PRW);
      pair_idx_in = k;
      pair_wdata_in = v;
   endtask : wpair
   task automatic pr(input brfpc_ptr_t m, input logic [7:0] dd, input logic [7:0] e);
      op(PRD);
      ptr_mode_in = m;
      ptr_disp_in = dd;
      note(K_MEM, {8'h00, e});
   endtask : pr
   function automatic logic [7:0] alu_ref(input int k, input logic [7:0] p, input logic [7:0] q);
      case (k)
         0: return p + q;
         1: return p - q;
         2: return p & q;
         3: return p | q;
         default: return p ^ q;
      endcase
   endfunction : alu_ref
   function automatic logic [15:0] seen(input int k);
      case (k)
         K_MEM:   return {8'h00, mem_rdata_out};
         K_HIT:   return {15'h0000, mem_hit_out};
         K_REG:   return {8'h00, reg_rdata_out};
         K_PAIR:  return pair_rdata_out;
         K_PSW:   return {8'h00, psw_out};
         K_PC:    return pc_out;
         K_FET:   return fetch_addr_out;
         K_OEN:   return {15'h0000, reset_pin_oe_n_out};
         K_PIN:   return {15'h0000, reset_pin_out};
         K_ROM:   return rom_addr_out;
         default: return {11'h000, psw_out[7], psw_out[3:0]};
      endcase
   endfunction : seen
   // watcher: compares outputs against the oldest due notes
   always @(posedge core_clk_in) begin
      cyc = cyc + 1;
      #1;
      while (notes.size() > 0 && notes[0].due == cyc) begin
         check(seen(notes[0].kind), notes[0].val);
         void'(notes.pop_front());
      end
   end
   always @(posedge core_clk_in) begin
      if (cyc >= LIMIT) begin
         mismatches++;
         final_report();
      end
   end
   ////////////////////////////////////////////////
   initial begin
      void'($urandom(75440));
      repeat (2) @(negedge core_clk_in);
      rst_in = 1'b0;
      note(K_JB, 16'h0010);
      note(K_OEN, 16'h0001);
      note(K_ROM, 16'hFFFE);
      note(K_FET, 16'hC03E, 3);
      note(K_PC, 16'hC040, 3);
      repeat (3) op(IDL);
      op(STP);
      pc_len_in = 3'h1;
      note(K_FET, 16'hC03F);
      note(K_PC, 16'hC041);
      op(JMP);
      pc_target_in = 16'hFFFF;
      op(STP);
      pc_len_in = 3'h2;
      note(K_PC, 16'h0003);
      op(STP | JMP);
      pc_target_in = 16'hC100;
      note(K_FET, 16'hC100);
      op(FLG);
      flags_in = 4'h6;
      note(K_PSW, 16'h0060);
      op(BNK);
      bank_in = 4'h3;
      note(K_PSW, 16'h00E3);
      op(FLG);
      note(K_PSW, 16'h0063);
      wr(PSW_ADDR, 8'hF5);
      note(K_PSW, 16'h00E5);
      rd(PSW_ADDR, 8'hE5, 1'b1);
      wr(PSW_ADDR, 8'hE6);
      note(K_PSW, 16'h00E6);
      op(PSL);
      psw_val_in = 8'h47;
      note(K_PSW, 16'h0047);
      foreach (edges[i]) begin
         x = 8'($urandom);
         wr(edges[i], x);
         rd(edges[i], (i < 2) ? x : 8'h00, 1'(i < 2));
      end
      for (int i = 0; i < 6; i++) begin
         a = RAM_LO + 16'($urandom_range(1023));
         x = 8'($urandom);
         wr(a, x);
         rd(a, x, 1'b1);
      end
      x = 8'($urandom);
      wr(16'h00C0, x, 1'b1);
      rd(16'h00C0, x, 1'b1);
      wr(DIR_HI, ~x);
      rd(DIR_HI, ~x, 1'b1, 1'b1);
      for (int b = 0; b < 16; b++) begin
         op(BNK);
         bank_in = 4'(b);
         x = 8'($urandom);
         wreg(3'(b), x);
         rd(RAM_LO + 16'(8 * b) + 16'(b % 8), x, 1'b1);
         wr(RAM_LO + 16'(8 * b + 7), ~x);
         op(IDL);
         reg_idx_in = IX_H;
         note(K_REG, {8'h00, ~x});
      end
      for (int k = 0; k < 4; k++) begin
         w = 16'($urandom);
         wpair(2'(k), w);
         rd(16'h00B8 + 16'(2 * k + 1), w[15:8], 1'b1);
         op(IDL);
         reg_idx_in = 3'(2 * k);
         note(K_PAIR, w);
         note(K_REG, {8'h00, w[7:0]});
      end
      for (int k = 0; k < 5; k++) begin
         x = 8'($urandom);
         y = 8'($urandom);
         wreg(IX_E, x);
         op(ALU);
         alu_op_in = brfpc_alu_t'(k);
         alu_dst_in = IX_E;
         alu_src_in = y;
         op(IDL);
         note(K_REG, {8'h00, alu_ref(k, x, y)});
      end
      foreach (d[k]) d[k] = 8'($urandom);
      wpair(2'h3, 16'h0120);
      wpair(2'h2, 16'h0200);
      wreg(IX_C, 8'h10);
      wr(16'h0120, d[0]);
      wr(16'h011E, d[1]);
      wr(16'h0130, d[2]);
      wr(16'h0200, d[3]);
      wr(16'h0121, d[4]);
      pr(PM_HL, 8'h00, d[0]);
      pr(PM_HL_D, 8'hFE, d[1]);
      pr(PM_HL_C, 8'h00, d[2]);
      pr(PM_DE, 8'h00, d[3]);
      pr(PM_HL_INC, 8'h00, d[0]);
      pr(PM_HL, 8'h00, d[4]);
      pr(PM_DEC_HL, 8'h00, d[0]);
      op(PWR);
      ptr_mode_in = PM_HL_D;
      ptr_disp_in = 8'h05;
      ptr_wdata_in = d[5];
      rd(16'h0125, d[5], 1'b1);
      c = 8'h80 | 8'($urandom);
      w = {8'($urandom_range(int'(c) - 1)), 8'($urandom)};
      wpair(2'h0, w);
      wreg(IX_C, c);
      op(DIV);
      op(IDL);
      note(K_PAIR, {8'(w % c), 8'(w / c)});
      wreg(IX_C, 8'h00);
      op(DIV);
      op(IDL);
      note(K_PAIR, {8'(w % c), 8'(w / c)});
      op(JMP);
      pc_target_in = 16'h0440;
      note(K_OEN, 16'h0001, 2);
      op(JMP);
      pc_target_in = RAM_HI;
      note(K_FET, RAM_HI);
      note(K_OEN, 16'h0000, 2);
      note(K_PIN, 16'h0000, 2);
      repeat (4) op(IDL);
      final_report();
   end
endmodule : banked_register_file_pc_tb
`default_nettype wire

// [sim/brfpc_rom_model.sv]
// brfpc_rom_model: program memory holding the reset vector
// assumes the core presents an address and takes the byte one cycle later
`timescale 1ns/1ps
`default_nettype none
module brfpc_rom_model #(
   parameter logic [15:0] VECTOR = 16'hC03E
) (
   input  wire logic        core_clk_in,
   input  wire logic [15:0] rom_addr_in,
   output var  logic [7:0]  rom_data_out
);
   initial rom_data_out = 8'h5A;
   // vector bytes, elsewhere a pattern that never repeats the last byte
   always @(posedge core_clk_in) begin
      if (rom_addr_in == 16'hFFFF) begin
         rom_data_out <= VECTOR[15:8];
      end else if (rom_addr_in == 16'hFFFE) begin
         rom_data_out <= VECTOR[7:0];
      end else begin
         rom_data_out <= ~rom_data_out;
      end
   end
endmodule : brfpc_rom_model
`default_nettype wire
